/* File: decimal_instruction_execute_unit.sv */
// Purpose: Execute datapath for decimal sign-plus-digit instructions
// Assumes: Storage answers a request with a one-cycle MEM_ACK
// Notes: Arithmetic goes through binary; results keep 11 digits
//
// Functional notes
// [RL1] Add: A plus B into D, store
// [RL2] Subtract: A minus B into D, store
// [RL3] Sum in C and D; C checks
// [RL4] Letters B..I suppress reverse-arithmetic check
// [RL5] Suppress early; other subinstructions after store
// [RL6] Sections shift A, B and result
// [RL7] Multiply stores high or low half
// [RL8] Divide stores quotient or remainder
// [RL9] Compare sets plus, minus or zero
// [RL10] Substitute one field from second word
// [RL11] Blank leading zeros, ignore second operand
// [RL12] Normalize left, count into B
// [RL13] Transfer first operand through D unchanged
// [RL14] Mask zero or space passes, else ignore
// [RL15] Jump to W, link U into V word
// [RL16] Conditional jump on match, else next address
// [RL17] Buffer transfer copies first operand
// [RL18] Load storage address from field digits
// [RL19] Copy current instruction into shift table
// [RL20] Channel clear writes space codes
// [RL21] Probe reports finished channel search
// [RL22] Handover starts selected plugboard step
// [RL23] Sign plus 11 digits; double product
`timescale 1ns/100ps
`default_nettype none
module decimal_instruction_execute_unit (
	input wire logic CLK,
	input wire logic RST,
	input wire logic GO,
	input wire logic [47:0] INSTR,
	output logic BUSY,
	output logic DONE,
	output logic [11:0] NEXT_INSTR_ADDR,
	output logic SUB_START,
	output logic [3:0] SUB_CODE,
	output logic STEP_START,
	output logic [11:0] STEP_SEL,
	output logic MEM_REQ,
	output logic MEM_WE,
	output logic [11:0] MEM_ADDR,
	output logic [47:0] MEM_WDATA,
	input wire logic [47:0] MEM_RDATA,
	input wire logic MEM_ACK,
	input wire logic SEARCH_DONE,
	input wire logic [7:0] ADDR,
	input wire logic [47:0] WDATA,
	input wire logic WE,
	input wire logic RE,
	output logic [47:0] RDATA
);
	typedef enum logic [3:0] {S_IDLE, S_DEC, S_RD_U, S_RD_V, S_EXEC,
		S_CHECK, S_STORE, S_RD_LINK, S_WR_LINK, S_FINISH} state_t;

	state_t state_r;
	dec_pkg::cond_t cond_r;
	logic [47:0] current_instruction_store_r;
	logic [47:0] accumulator_a_r, accumulator_b_r;
	logic [47:0] result_register_c_r, result_register_d_r;
	logic [47:0] xfer_buf_r, rdata_r;
	logic [35:0] shift_table_r;
	logic [11:0] next_address_register_r, nxt_r, addr_r;
	logic [27:0] general_storage_address_reg_r;
	logic check_err_r, div_err_r, probe_r, srch_s1_r, srch_s2_r;
	logic [7:0] op;
	logic [11:0] u_f, v_f, w_f;
	logic [3:0] sc;
	logic suppressed, taken, chk_bad, lead;
	logic [39:0] xa, xb, quo, rem;
	logic [79:0] prod;
	logic [47:0] sum_w, x_a, x_b, x_c, x_d, x_w;
	logic [43:0] nm;
	logic [3:0] ncnt;

	function automatic logic [39:0] to_bin(input logic [43:0] m);
		logic [39:0] v;
		v = 40'h0;
		for (int i = 10; i >= 0; i--) begin
			v = v * 40'hA + {36'h0, (m[i*4 +: 4] > 4'h9) ? 4'h0 : m[i*4 +: 4]};
		end
		return v;
	endfunction

	// Keeps the low eleven digits; overflow is lost here
	function automatic logic [43:0] to_bcd(input logic [79:0] v);
		logic [43:0] m;
		logic [79:0] t;
		t = v;
		m = 44'h0;
		for (int i = 0; i < 11; i++) begin
			m[i*4 +: 4] = 4'(t % 80'hA);
			t = t / 80'hA;
		end
		return m;
	endfunction

	function automatic logic is_neg(input logic [47:0] w);
		return w[3:0] == dec_pkg::CH_MINUS;
	endfunction

	function automatic logic [47:0] mkword(input logic n,
		input logic [43:0] m);
		return {m, (n && m != 44'h0) ? dec_pkg::CH_MINUS : dec_pkg::CH_PLUS};
	endfunction

	function automatic logic [47:0] f_add(input logic [47:0] a,
		input logic [47:0] b, input logic sub);
		logic [39:0] x, y;
		logic na, nb;
		x = to_bin(a[47:4]);
		y = to_bin(b[47:4]);
		na = is_neg(a);
		nb = is_neg(b) ^ sub;
		if (na == nb)
			return mkword(na, to_bcd({40'h0, x + y}));
		else if (x >= y)
			return mkword(na, to_bcd({40'h0, x - y}));
		return mkword(nb, to_bcd({40'h0, y - x}));
	endfunction

	function automatic dec_pkg::cond_t f_cmp(input logic [47:0] a,
		input logic [47:0] b);
		logic [39:0] x, y;
		logic na, nb, gt;
		x = to_bin(a[47:4]);
		y = to_bin(b[47:4]);
		na = is_neg(a) && x != 40'h0;
		nb = is_neg(b) && y != 40'h0;
		if (na == nb && x == y)
			return dec_pkg::CND_ZERO;
		gt = (na != nb) ? nb : (na ? x < y : x > y);
		return gt ? dec_pkg::CND_PLUS : dec_pkg::CND_MINUS;
	endfunction

	function automatic logic [47:0] shift_word(input logic [47:0] w,
		input logic [11:0] sec);
		logic [43:0] r;
		int n, s;
		r = w[47:4];
		n = int'(sec[7:4]) * 10 + int'(sec[3:0]);
		for (int i = 0; i < 11; i++) begin
			case (sec[11:8])
			dec_pkg::SH_LEFT: s = i - n;
			dec_pkg::SH_RIGHT: s = i + n;
			dec_pkg::SH_ROT: s = (i + n) % 11;
			default: s = i;
			endcase
			r[i*4 +: 4] = (s >= 0 && s < 11) ? w[s*4+4 +: 4] : 4'h0;
		end
		return {r, w[3:0]};
	endfunction

	function automatic logic is_arith(input logic [7:0] o);
		return o inside {dec_pkg::add_op, dec_pkg::subtract_op,
			dec_pkg::multiply_keep_high, dec_pkg::multiply_keep_low,
			dec_pkg::divide_keep_quotient, dec_pkg::divide_keep_remainder,
			dec_pkg::compare_op};
	endfunction

	function automatic logic needs_v(input logic [7:0] o);
		return is_arith(o) || o inside {dec_pkg::masked_move_op,
			dec_pkg::substitute_first_field,
			dec_pkg::substitute_second_field,
			dec_pkg::substitute_third_field};
	endfunction

	function automatic logic needs_u(input logic [7:0] o);
		return needs_v(o) || o inside {dec_pkg::leading_zero_blank,
			dec_pkg::normalize_op, dec_pkg::arith_transfer_op,
			dec_pkg::block_buffer_move};
	endfunction

	function automatic logic is_addsub(input logic [7:0] o);
		return o == dec_pkg::add_op || o == dec_pkg::subtract_op;
	endfunction

	assign op = current_instruction_store_r[47:40];
	assign u_f = current_instruction_store_r[39:28];
	assign v_f = current_instruction_store_r[27:16];
	assign w_f = current_instruction_store_r[15:4];
	assign sc = current_instruction_store_r[3:0];
	assign suppressed = sc >= dec_pkg::SC_SUP_LO && sc <= dec_pkg::SC_SUP_HI;
	assign taken = op == dec_pkg::always_jump
		|| (op == dec_pkg::jump_if_minus && cond_r == dec_pkg::CND_MINUS)
		|| (op == dec_pkg::jump_if_plus && cond_r == dec_pkg::CND_PLUS)
		|| (op == dec_pkg::jump_if_zero && cond_r == dec_pkg::CND_ZERO);

	assign xa = to_bin(accumulator_a_r[47:4]);
	assign xb = to_bin(accumulator_b_r[47:4]);
	assign prod = {40'h0, xa} * {40'h0, xb}; // RL23
	assign quo = (xb == 40'h0) ? 40'h0 : xa / xb;
	assign rem = (xb == 40'h0) ? 40'h0 : xa % xb;
	assign sum_w = f_add(accumulator_a_r, accumulator_b_r,
		op == dec_pkg::subtract_op); // RL1 RL2
	// Reverse arithmetic on the C copy must give back operand A
	assign chk_bad = f_cmp(f_add(result_register_c_r, accumulator_b_r,
		op != dec_pkg::subtract_op), accumulator_a_r) != dec_pkg::CND_ZERO;

	always_comb begin
		x_a = accumulator_a_r;
		x_b = accumulator_b_r;
		x_c = result_register_c_r;
		x_d = result_register_d_r;
		x_w = accumulator_a_r;
		nm = accumulator_a_r[47:4];
		ncnt = 4'h0;
		lead = 1'b1;
		case (op)
		dec_pkg::add_op, dec_pkg::subtract_op: begin
			x_c = sum_w; // RL3
			x_d = sum_w;
			x_w = shift_word(sum_w, shift_table_r[11:0]); // RL6
		end
		dec_pkg::multiply_keep_high, dec_pkg::multiply_keep_low: begin
			x_c = mkword(is_neg(accumulator_a_r) ^ is_neg(accumulator_b_r),
				to_bcd(prod / dec_pkg::DEC_SCALE)); // RL23
			x_d = mkword(is_neg(accumulator_a_r) ^ is_neg(accumulator_b_r),
				to_bcd(prod % dec_pkg::DEC_SCALE));
			x_w = shift_word((op == dec_pkg::multiply_keep_high) ? x_c : x_d,
				shift_table_r[11:0]); // RL7
		end
		dec_pkg::divide_keep_quotient, dec_pkg::divide_keep_remainder: begin
			x_c = mkword(is_neg(accumulator_a_r), to_bcd({40'h0, rem}));
			x_d = mkword(is_neg(accumulator_a_r) ^ is_neg(accumulator_b_r),
				to_bcd({40'h0, quo}));
			x_w = shift_word((op == dec_pkg::divide_keep_quotient) ? x_d : x_c,
				shift_table_r[11:0]); // RL8
		end
		dec_pkg::substitute_first_field:
			x_w[39:28] = accumulator_b_r[39:28]; // RL10
		dec_pkg::substitute_second_field:
			x_w[27:16] = accumulator_b_r[27:16];
		dec_pkg::substitute_third_field:
			x_w[15:4] = accumulator_b_r[15:4];
		dec_pkg::leading_zero_blank: begin
			for (int i = 11; i >= 1; i--) begin
				if (lead && x_w[i*4 +: 4] == 4'h0)
					x_w[i*4 +: 4] = dec_pkg::CH_SPACE; // RL11
				else
					lead = 1'b0;
			end
		end
		dec_pkg::normalize_op: begin
			for (int k = 0; k < 11; k++) begin
				if (nm != 44'h0 && nm[43:40] == 4'h0) begin
					nm = {nm[39:0], 4'h0}; // RL12
					ncnt = ncnt + 4'h1;
				end
			end
			x_a = {nm, accumulator_a_r[3:0]};
			x_w = x_a;
			x_b = {to_bcd({76'h0, ncnt}), dec_pkg::CH_PLUS};
		end
		dec_pkg::arith_transfer_op:
			x_d = accumulator_a_r; // RL13
		dec_pkg::masked_move_op: begin
			for (int i = 0; i < 12; i++) begin
				if (accumulator_b_r[i*4 +: 4] != 4'h0
					&& accumulator_b_r[i*4 +: 4] != dec_pkg::CH_SPACE)
					x_w[i*4 +: 4] = dec_pkg::CH_IGNORE; // RL14
			end
		end
		default: x_w = accumulator_a_r; // RL17
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			state_r <= S_IDLE;
			addr_r <= 12'h000;
			nxt_r <= 12'h000;
			xfer_buf_r <= 48'h0;
			current_instruction_store_r <= 48'h0;
		end else begin
			case (state_r)
			S_IDLE: if (GO) begin
				current_instruction_store_r <= INSTR;
				state_r <= S_DEC;
			end
			S_DEC: begin
				nxt_r <= taken ? w_f : next_address_register_r; // RL16
				addr_r <= needs_u(op) ? u_f : (taken ? v_f : w_f);
				xfer_buf_r <= {12{dec_pkg::CH_SPACE}}; // RL20
				if (needs_u(op))
					state_r <= S_RD_U;
				else if (op == dec_pkg::channel_blank_op)
					state_r <= S_STORE;
				else if (taken)
					state_r <= S_RD_LINK; // RL15
				else
					state_r <= S_FINISH;
			end
			S_RD_U: if (MEM_ACK) begin
				addr_r <= needs_v(op) ? v_f : w_f;
				state_r <= needs_v(op) ? S_RD_V : S_EXEC;
			end
			S_RD_V: if (MEM_ACK)
				state_r <= S_EXEC;
			S_EXEC: begin
				addr_r <= w_f;
				xfer_buf_r <= x_w;
				if (op == dec_pkg::compare_op)
					state_r <= S_FINISH;
				else if (is_addsub(op) && !suppressed)
					state_r <= S_CHECK; // RL4
				else
					state_r <= S_STORE;
			end
			S_CHECK: state_r <= S_STORE;
			S_STORE: if (MEM_ACK)
				state_r <= S_FINISH; // RL5
			S_RD_LINK: if (MEM_ACK) begin
				xfer_buf_r <= {MEM_RDATA[47:16], u_f, MEM_RDATA[3:0]}; // RL15
				state_r <= S_WR_LINK;
			end
			S_WR_LINK: if (MEM_ACK)
				state_r <= S_FINISH;
			S_FINISH: state_r <= S_IDLE;
			default: state_r <= S_IDLE;
			endcase
		end
	end

	// Arithmetic registers
	always_ff @(posedge CLK) begin
		if (RST) begin
			accumulator_a_r <= 48'h0;
			accumulator_b_r <= 48'h0;
			result_register_c_r <= 48'h0;
			result_register_d_r <= 48'h0;
		end else if (state_r == S_RD_U && MEM_ACK) begin
			accumulator_a_r <= is_arith(op) ?
				shift_word(MEM_RDATA, shift_table_r[35:24]) : MEM_RDATA; // RL6
			if (op inside {dec_pkg::divide_keep_quotient,
				dec_pkg::divide_keep_remainder})
				result_register_c_r <= MEM_RDATA;
		end else if (state_r == S_RD_V && MEM_ACK) begin
			accumulator_b_r <= is_arith(op) ?
				shift_word(MEM_RDATA, shift_table_r[23:12]) : MEM_RDATA;
		end else if (state_r == S_EXEC) begin
			accumulator_a_r <= x_a;
			accumulator_b_r <= x_b;
			result_register_c_r <= x_c;
			result_register_d_r <= x_d;
		end
	end

	// Branch condition, storage address and probe result
	always_ff @(posedge CLK) begin
		if (RST) begin
			cond_r <= dec_pkg::CND_ZERO;
			general_storage_address_reg_r <= 28'h0;
			probe_r <= 1'b0;
		end else if (state_r == S_EXEC && op == dec_pkg::compare_op) begin
			cond_r <= f_cmp(accumulator_a_r, accumulator_b_r); // RL9
		end else if (state_r == S_DEC) begin
			if (op == dec_pkg::load_storage_address_op)
				general_storage_address_reg_r <= {u_f[7:0], v_f, w_f[11:4]}; // RL18
			if (op == dec_pkg::search_done_probe)
				probe_r <= srch_s2_r; // RL21
		end
	end

	// Search status arrives from another unit, so synchronise it
	always_ff @(posedge CLK) begin
		if (RST) begin
			srch_s1_r <= 1'b0;
			srch_s2_r <= 1'b0;
		end else begin
			srch_s1_r <= SEARCH_DONE;
			srch_s2_r <= srch_s1_r;
		end
	end

	// Software-written registers; the instruction wins a same-cycle write
	always_ff @(posedge CLK) begin
		if (RST) begin
			shift_table_r <= dec_pkg::SHIFT_RST;
			next_address_register_r <= dec_pkg::NEXT_RST;
		end else begin
			if (state_r == S_DEC && op == dec_pkg::load_shift_table_op)
				shift_table_r <= current_instruction_store_r[39:4]; // RL19
			else if (WE && ADDR == dec_pkg::REG_SHIFT)
				shift_table_r <= WDATA[35:0];
			if (WE && ADDR == dec_pkg::REG_NEXT)
				next_address_register_r <= WDATA[11:0];
		end
	end

	// Sticky errors: a set in the clearing cycle survives
	always_ff @(posedge CLK) begin
		if (RST) begin
			check_err_r <= 1'b0;
			div_err_r <= 1'b0;
		end else begin
			if (state_r == S_CHECK && chk_bad)
				check_err_r <= 1'b1; // RL4
			else if (WE && ADDR == dec_pkg::REG_STATUS && WDATA[dec_pkg::ST_CHK])
				check_err_r <= 1'b0;
			if (state_r == S_EXEC && xb == 40'h0 && op inside
				{dec_pkg::divide_keep_quotient, dec_pkg::divide_keep_remainder})
				div_err_r <= 1'b1;
			else if (WE && ADDR == dec_pkg::REG_STATUS && WDATA[dec_pkg::ST_DIV])
				div_err_r <= 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST)
			rdata_r <= 48'h0;
		else if (RE) begin
			case (ADDR)
			dec_pkg::REG_SHIFT: rdata_r <= {12'h0, shift_table_r};
			dec_pkg::REG_NEXT: rdata_r <= {36'h0, next_address_register_r};
			dec_pkg::REG_STATUS: rdata_r <= {42'h0, probe_r, div_err_r,
				check_err_r, cond_r, BUSY};
			dec_pkg::REG_STORAGE_ADDR:
				rdata_r <= {20'h0, general_storage_address_reg_r};
			dec_pkg::REG_ACC_A: rdata_r <= accumulator_a_r;
			dec_pkg::REG_ACC_B: rdata_r <= accumulator_b_r;
			dec_pkg::REG_C: rdata_r <= result_register_c_r;
			dec_pkg::REG_D: rdata_r <= result_register_d_r;
			default: rdata_r <= 48'h0;
			endcase
		end
	end

	assign RDATA = rdata_r;
	assign BUSY = state_r != S_IDLE;
	assign DONE = state_r == S_FINISH;
	assign NEXT_INSTR_ADDR = nxt_r;
	assign SUB_START = DONE && sc != 4'h0 && sc != dec_pkg::SC_SUP_ONLY
		&& op != dec_pkg::control_handover_op; // RL5
	assign SUB_CODE = sc;
	assign STEP_START = DONE && op == dec_pkg::control_handover_op; // RL22
	assign STEP_SEL = u_f;
	assign MEM_REQ = state_r inside {S_RD_U, S_RD_V, S_STORE, S_RD_LINK,
		S_WR_LINK};
	assign MEM_WE = state_r == S_STORE || state_r == S_WR_LINK;
	assign MEM_ADDR = addr_r;
	assign MEM_WDATA = xfer_buf_r;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	chk_add_store: assert property (state_r == S_STORE && MEM_ACK
		&& op == dec_pkg::add_op |-> MEM_WDATA ==
		shift_word(result_register_d_r, shift_table_r[11:0])) // RL1
		else $error("add store differs from D");
	chk_sub_copy: assert property (state_r == S_EXEC && is_addsub(op)
		|=> result_register_c_r == result_register_d_r) // RL3
		else $error("C and D copies differ");
	chk_check_skip: assert property (state_r == S_EXEC && is_addsub(op)
		|=> (state_r == S_CHECK) == !$past(suppressed)) // RL4
		else $error("check pass wrong for subinstruction");
	chk_sub_after: assert property (SUB_START && is_arith(op)
		&& op != dec_pkg::compare_op |-> $past(state_r) == S_STORE) // RL5
		else $error("subinstruction before store");
	chk_cmp_equal: assert property (state_r == S_EXEC
		&& op == dec_pkg::compare_op && accumulator_a_r == accumulator_b_r
		|=> cond_r == dec_pkg::CND_ZERO && DONE) // RL9
		else $error("equal compare not zero");
	chk_div_zero: assert property (state_r == S_EXEC && xb == 40'h0
		&& op == dec_pkg::divide_keep_quotient |=> div_err_r) // RL8
		else $error("divide by zero not flagged");
	chk_link_word: assert property (state_r == S_WR_LINK |->
		MEM_WDATA[15:4] == u_f && MEM_ADDR == v_f) // RL15
		else $error("return link malformed");
	chk_nojump_next: assert property (state_r == S_DEC
		&& op == dec_pkg::jump_if_zero && cond_r != dec_pkg::CND_ZERO
		|=> DONE && NEXT_INSTR_ADDR == $past(next_address_register_r)) // RL16
		else $error("untaken jump went wrong way");
	chk_clear_spaces: assert property (state_r == S_STORE
		&& op == dec_pkg::channel_blank_op
		|-> MEM_WDATA == {12{dec_pkg::CH_SPACE}}) // RL20
		else $error("channel clear not spaces");
	chk_shift_load: assert property (state_r == S_DEC
		&& op == dec_pkg::load_shift_table_op
		|=> shift_table_r == $past(current_instruction_store_r[39:4])) // RL19
		else $error("shift table not loaded");
	chk_step_start: assert property (GO && !BUSY && INSTR[47:40] ==
		dec_pkg::control_handover_op |-> ##2 STEP_START) // RL22
		else $error("handover step missing");

	cov_add_checked: cover property (state_r == S_CHECK && !chk_bad);
	cov_jump_taken: cover property (state_r == S_WR_LINK && MEM_ACK);
	cov_divide: cover property (state_r == S_EXEC
		&& op == dec_pkg::divide_keep_remainder);
	cov_handover: cover property (STEP_START);
endmodule
`default_nettype wire

/* File: dec_pkg.sv */
// Purpose: Shared constants for the decimal execute unit
// Assumes: Words are twelve 4-bit characters, sign in the lowest one
// Notes: Character and most operation codes are free encodings
`default_nettype none
package dec_pkg;
	localparam int WW = 48;
	localparam int AW = 12;
	// Character codes
	localparam logic [3:0] CH_SPACE = 4'hA;
	localparam logic [3:0] CH_PLUS = 4'hB;
	localparam logic [3:0] CH_MINUS = 4'hD;
	localparam logic [3:0] CH_IGNORE = 4'hF;
	// Subinstruction characters B..I are 1..8, F is check suppress only
	localparam logic [3:0] SC_SUP_LO = 4'h1;
	localparam logic [3:0] SC_SUP_HI = 4'h8;
	localparam logic [3:0] SC_SUP_ONLY = 4'h5;
	// Shift section: type digit then two amount digits
	localparam logic [3:0] SH_LEFT = 4'h1;
	localparam logic [3:0] SH_RIGHT = 4'h2;
	localparam logic [3:0] SH_ROT = 4'h3;
	// Half of a double-length product, 10**11
	localparam logic [79:0] DEC_SCALE = 80'h174876E800;
	// Operation codes
	localparam logic [7:0] add_op = 8'h14;
	localparam logic [7:0] subtract_op = 8'h22;
	localparam logic [7:0] multiply_keep_low = 8'h43;
	localparam logic [7:0] multiply_keep_high = 8'h44;
	localparam logic [7:0] divide_keep_quotient = 8'h48;
	localparam logic [7:0] divide_keep_remainder = 8'h49;
	localparam logic [7:0] compare_op = 8'h30;
	localparam logic [7:0] substitute_first_field = 8'h31;
	localparam logic [7:0] substitute_second_field = 8'h32;
	localparam logic [7:0] substitute_third_field = 8'h33;
	localparam logic [7:0] leading_zero_blank = 8'h34;
	localparam logic [7:0] normalize_op = 8'h35;
	localparam logic [7:0] arith_transfer_op = 8'h36;
	localparam logic [7:0] masked_move_op = 8'h37;
	localparam logic [7:0] always_jump = 8'h50;
	localparam logic [7:0] jump_if_minus = 8'h51;
	localparam logic [7:0] jump_if_plus = 8'h52;
	localparam logic [7:0] jump_if_zero = 8'h53;
	localparam logic [7:0] block_buffer_move = 8'h60;
	localparam logic [7:0] load_storage_address_op = 8'h61;
	localparam logic [7:0] load_shift_table_op = 8'h62;
	localparam logic [7:0] channel_blank_op = 8'h63;
	localparam logic [7:0] search_done_probe = 8'h64;
	localparam logic [7:0] control_handover_op = 8'h70;
	// Register offsets
	localparam logic [7:0] REG_SHIFT = 8'h00;
	localparam logic [7:0] REG_NEXT = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_STORAGE_ADDR = 8'h0C;
	localparam logic [7:0] REG_ACC_A = 8'h10;
	localparam logic [7:0] REG_ACC_B = 8'h14;
	localparam logic [7:0] REG_C = 8'h18;
	localparam logic [7:0] REG_D = 8'h1C;
	// Status bits
	localparam int ST_CHK = 3;
	localparam int ST_DIV = 4;
	localparam logic [35:0] SHIFT_RST = 36'h0;
	localparam logic [11:0] NEXT_RST = 12'h000;
	typedef enum logic [1:0] {CND_ZERO, CND_PLUS, CND_MINUS} cond_t;
endpackage
`default_nettype wire

/* File: word_store.sv */
// Purpose: Behavioural word storage on the far side of the execute unit
// Assumes: One request at a time, acknowledge one cycle long
// Notes: Read data is scrambled outside the acknowledge cycle
`timescale 1ns/100ps
`default_nettype none
module word_store (
	input wire logic CLK,
	input wire logic SLOW,
	input wire logic MEM_REQ,
	input wire logic MEM_WE,
	input wire logic [11:0] MEM_ADDR,
	input wire logic [47:0] MEM_WDATA,
	output logic [47:0] MEM_RDATA,
	output logic MEM_ACK
);
	logic [47:0] mem [0:255];
	logic [1:0] wait_r;
	initial begin
		MEM_ACK = 1'b0;
		MEM_RDATA = 48'h0;
		wait_r = 2'h0;
	end
	// Slow mode answers after four request cycles
	always @(posedge CLK) begin
		if (MEM_ACK) begin
			MEM_ACK <= 1'b0;
			MEM_RDATA <= ~MEM_RDATA;
			wait_r <= 2'h0;
		end else if (MEM_REQ && (!SLOW || wait_r == 2'h3)) begin
			MEM_ACK <= 1'b1;
			if (MEM_WE)
				mem[MEM_ADDR[7:0]] <= MEM_WDATA;
			else
				MEM_RDATA <= mem[MEM_ADDR[7:0]];
		end else begin
			// Released bus must not keep showing old data
			MEM_RDATA <= ~MEM_RDATA;
			if (MEM_REQ)
				wait_r <= wait_r + 2'h1;
		end
	end
endmodule
`default_nettype wire

/* File: decimal_instruction_execute_unit_test.sv */
// Purpose: Self-checking bench for the decimal execute unit
// Assumes: Shift table is cleared again after its one shifted add
// Notes: Storage is preloaded and inspected through the model array
`timescale 1ns/100ps
`default_nettype none
module decimal_instruction_execute_unit_test;
	logic CLK, RST, GO, WE, RE, SLOW, SEARCH_DONE;
	logic [47:0] INSTR, WDATA, RDATA, MEM_RDATA, MEM_WDATA, rd;
	logic [7:0] ADDR;
	logic BUSY, DONE, SUB_START, STEP_START, MEM_REQ, MEM_WE, MEM_ACK;
	logic [11:0] NEXT_INSTR_ADDR, STEP_SEL, MEM_ADDR;
	logic [3:0] SUB_CODE;
	logic sub_seen, step_seen;
	int n_errors = 0;
	int num_checks = 0;

	decimal_instruction_execute_unit i_dut (.CLK, .RST, .GO, .INSTR,
		.BUSY, .DONE, .NEXT_INSTR_ADDR, .SUB_START, .SUB_CODE,
		.STEP_START, .STEP_SEL, .MEM_REQ, .MEM_WE, .MEM_ADDR,
		.MEM_WDATA, .MEM_RDATA, .MEM_ACK, .SEARCH_DONE, .ADDR,
		.WDATA, .WE, .RE, .RDATA);
	word_store i_store (.CLK, .SLOW, .MEM_REQ, .MEM_WE, .MEM_ADDR,
		.MEM_WDATA, .MEM_RDATA, .MEM_ACK);

	initial begin
		CLK = 1'b0;
		forever #12.5 CLK = ~CLK;
	end

	task automatic final_report();
		if (n_errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [47:0] d);
		@(posedge CLK);
		WE <= 1'b1;
		ADDR <= a;
		WDATA <= d;
		@(posedge CLK);
		WE <= 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] a);
		@(posedge CLK);
		RE <= 1'b1;
		ADDR <= a;
		@(posedge CLK);
		RE <= 1'b0;
		#1 rd = RDATA;
	endtask

	function automatic logic [47:0] ins(input logic [7:0] op,
		input logic [11:0] u, input logic [11:0] v,
		input logic [11:0] w, input logic [3:0] sc);
		return {op, u, v, w, sc};
	endfunction

	// Returns inside the finishing cycle, pulses captured there
	task automatic run(input logic [47:0] i);
		int n;
		@(posedge CLK);
		GO <= 1'b1;
		INSTR <= i;
		@(posedge CLK);
		GO <= 1'b0;
		for (n = 0; n < 200; n++) begin
			#1;
			if (DONE === 1'b1)
				break;
			@(posedge CLK);
		end
		sub_seen = SUB_START;
		step_seen = STEP_START;
		chk({47'h0, DONE}, 48'h1);
		chk({47'h0, BUSY}, 48'h1);
	endtask

	task automatic s_add();
		i_store.mem[1] = 48'h00000000047B;
		i_store.mem[2] = 48'h00000000058B;
		run(ins(dec_pkg::add_op, 12'h001, 12'h002, 12'h003, 4'h0));
		chk(i_store.mem[3], 48'h00000000105B);
		chk({47'h0, sub_seen}, 48'h0);
		reg_rd(dec_pkg::REG_D);
		chk(rd, 48'h00000000105B);
		reg_rd(dec_pkg::REG_STATUS);
		chk({47'h0, rd[dec_pkg::ST_CHK]}, 48'h0);
		reg_rd(8'hFC);
		chk(rd, 48'h0);
	endtask

	task automatic s_sub();
		SLOW <= 1'b1;
		run(ins(dec_pkg::subtract_op, 12'h001, 12'h002, 12'h004, 4'h1));
		chk(i_store.mem[4], 48'h00000000011D);
		chk({47'h0, sub_seen}, 48'h1);
		chk({44'h0, SUB_CODE}, 48'h1);
		SLOW <= 1'b0;
	endtask

	task automatic s_jump();
		i_store.mem[5] = 48'h0;
		i_store.mem[6] = 48'h00000000777B;
		run(ins(dec_pkg::compare_op, 12'h001, 12'h002, 12'h000, 4'h0));
		reg_rd(dec_pkg::REG_STATUS);
		chk({46'h0, rd[2:1]}, 48'h2);
		run(ins(dec_pkg::jump_if_minus, 12'h123, 12'h005, 12'h040, 4'h0));
		chk({36'h0, NEXT_INSTR_ADDR}, 48'h040);
		chk(i_store.mem[5], 48'h000000001230);
		reg_wr(dec_pkg::REG_NEXT, 48'h077);
		run(ins(dec_pkg::jump_if_plus, 12'h123, 12'h006, 12'h040, 4'h0));
		chk({36'h0, NEXT_INSTR_ADDR}, 48'h077);
		chk(i_store.mem[6], 48'h00000000777B);
		run(ins(dec_pkg::jump_if_zero, 12'h123, 12'h006, 12'h040, 4'h0));
		chk({36'h0, NEXT_INSTR_ADDR}, 48'h077);
		run(ins(dec_pkg::compare_op, 12'h001, 12'h001, 12'h000, 4'h0));
		reg_rd(dec_pkg::REG_STATUS);
		chk({46'h0, rd[2:1]}, 48'h0);
	endtask

	task automatic s_logic();
		i_store.mem[7] = 48'h00000000005B;
		i_store.mem[9] = 48'h12345678901B;
		i_store.mem[10] = 48'h0A1A0A0A0A0A;
		run(ins(dec_pkg::leading_zero_blank, 12'h007, 12'h0, 12'h008, 4'h0));
		chk(i_store.mem[8], 48'hAAAAAAAAAA5B);
		run(ins(dec_pkg::masked_move_op, 12'h009, 12'h00A, 12'h00B, 4'h0));
		chk(i_store.mem[11], 48'h12F45678901B);
	endtask

	task automatic s_move();
		run(ins(dec_pkg::normalize_op, 12'h7, 12'h0, 12'h17, 4'h0));
		chk(i_store.mem[23], 48'h50000000000B);
		reg_rd(dec_pkg::REG_ACC_B);
		chk(rd, 48'h00000000010B);
		run(ins(dec_pkg::arith_transfer_op, 12'h9, 12'h0, 12'h18, 4'h0));
		chk(i_store.mem[24], 48'h12345678901B);
		reg_rd(dec_pkg::REG_D);
		chk(rd, 48'h12345678901B);
		run(ins(dec_pkg::block_buffer_move, 12'h9, 12'h0, 12'h19, 4'h0));
		chk(i_store.mem[25], 48'h12345678901B);
		run(ins(dec_pkg::substitute_second_field, 12'h9, 12'hA, 12'h1A,
			4'h0));
		chk(i_store.mem[26], 48'h12345A0A901B);
	endtask

	task automatic s_muldiv();
		i_store.mem[12] = 48'h10000000000B;
		i_store.mem[13] = 48'h00000000012D;
		i_store.mem[15] = 48'h0;
		run(ins(dec_pkg::multiply_keep_high, 12'hC, 12'hD, 12'h14, 4'h0));
		chk(i_store.mem[20], 48'h00000000001D);
		reg_rd(dec_pkg::REG_D);
		chk(rd, 48'h20000000000D);
		run(ins(dec_pkg::divide_keep_remainder, 12'hC, 12'hD, 12'h14, 4'h0));
		chk(i_store.mem[20], 48'h00000000004B);
		reg_rd(dec_pkg::REG_D);
		chk(rd, 48'h00833333333D);
		run(ins(dec_pkg::divide_keep_quotient, 12'hC, 12'hF, 12'h14, 4'h0));
		reg_rd(dec_pkg::REG_STATUS);
		chk({47'h0, rd[dec_pkg::ST_DIV]}, 48'h1);
	endtask

	task automatic s_special();
		run(ins(dec_pkg::load_shift_table_op, 12'h101, 12'h0, 12'h201,
			4'h0));
		reg_rd(dec_pkg::REG_SHIFT);
		chk(rd, 48'h101000201);
		run(ins(dec_pkg::add_op, 12'h1, 12'h2, 12'h15, 4'h0));
		chk(i_store.mem[21], 48'h00000000052B);
		reg_wr(dec_pkg::REG_SHIFT, 48'h0);
		run(ins(dec_pkg::load_storage_address_op, 12'h123, 12'h456,
			12'h789, 4'h0));
		reg_rd(dec_pkg::REG_STORAGE_ADDR);
		chk(rd, 48'h2345678);
		run(ins(dec_pkg::channel_blank_op, 12'h0, 12'h0, 12'h16, 4'h0));
		chk(i_store.mem[22], {12{dec_pkg::CH_SPACE}});
		SEARCH_DONE <= 1'b1;
		run(ins(dec_pkg::search_done_probe, 12'h0, 12'h0, 12'h0, 4'h0));
		reg_rd(dec_pkg::REG_STATUS);
		chk({47'h0, rd[5]}, 48'h1);
	endtask

	task automatic s_hand();
		run(ins(dec_pkg::control_handover_op, 12'h0C5, 12'h0, 12'h0, 4'h2));
		chk({47'h0, step_seen}, 48'h1);
		chk({36'h0, STEP_SEL}, 48'h0C5);
		chk({47'h0, sub_seen}, 48'h0);
	endtask

	initial begin
		RST = 1'b1;
		GO = 1'b0;
		WE = 1'b0;
		RE = 1'b0;
		SLOW = 1'b0;
		SEARCH_DONE = 1'b0;
		INSTR = 48'h0;
		WDATA = 48'h0;
		ADDR = 8'h0;
		repeat (3) @(posedge CLK);
		RST <= 1'b0;
		s_add();
		s_sub();
		s_jump();
		s_logic();
		s_move();
		s_muldiv();
		s_special();
		s_hand();
		final_report();
	end

	// Whole run needs well under a thousand cycles
	initial begin
		#(25 * 5000);
		n_errors++;
		final_report();
	end
endmodule
`default_nettype wire
